/* hdl/bbw_burst_sram.v */
// Operation
// - Write starts on low write select at K rise; beat0 then, address and beat1 on K# rise.
// - Read drives word0 at output-neg rise of t+1, word1 at output-pos rise of t+2.
// - x8: both nibble enables low write all eight bits of the beat.
// - x8: enable0 low, enable1 high writes bits 3..0, keeps 7..4.
// - x8: enable0 high, enable1 low writes bits 7..4, keeps 3..0.
// - x18: both byte enables low write all eighteen bits of the beat.
// - x18: enable0 low, enable1 high writes bits 8..0, keeps 17..9.
// - x18: enable0 high, enable1 low writes bits 17..9, keeps 8..0.
// - x8 and x18: both enables high write nothing for that beat.
// - x9: single enable low writes bits 8..0 of the beat.
// - x9 and x36: all enables high write nothing for that beat.
// - x36: all four enables low write all thirty-six bits.
// - x36: only enable0 low writes bits 8..0, keeps the rest.
// - x36: only enable1 low writes bits 17..9, keeps the rest.
// - x36: only enable2 low writes bits 26..18, keeps the rest.
// - x36: only enable3 low writes bits 35..27, keeps the rest.
// - Enables may differ between beats; each beat uses its own sampled enables.
// - After power-up both ports are deselected and read outputs are not driven.
// - First word uses the latched address, second the next sequential location.
// - Cycle t starts the transfer; t+1 and t+2 are the following cycles.
// - Write beats are registered on both K and K# rising edges.
// - Read data launches on output clock rises, or K clocks in single clock mode.
`timescale 1ns/1ps
`include "bbw_defines.vh"

module bbw_burst_sram (
	input wire clk_i,
	input wire rst_i,
	input wire k_i,
	input wire k_n_i,
	input wire c_i,
	input wire c_n_i,
	input wire [1:0] cfg_mode_i,
	input wire [`BBW_AW-1:0] addr_i,
	input wire [`BBW_DW-1:0] d_i,
	input wire write_port_select_n_i,
	input wire read_port_select_n_i,
	input wire [`BBW_BW-1:0] byte_lane_write_enable_n_i,
	input wire [`BBW_NW-1:0] nibble_lane_write_enable_n_i,
	output reg [`BBW_DW-1:0] q_o,
	output reg q_oe_o,
	output reg single_clock_mode_o
);

	// =============================================================
	// Lane mask and merge helpers
	function [`BBW_DW-1:0] lane_mask;
		input [1:0] mode;
		input [`BBW_BW-1:0] bsel_n;
		input [`BBW_NW-1:0] nsel_n;
		reg [`BBW_DW-1:0] m;
		begin
			m = `BBW_ZERO_DW;
			case (mode)
				`BBW_MODE_X8: begin
					if (!nsel_n[0])
						m[`BBW_NIB0_HI:0] = {(`BBW_NIB0_HI+1){1'b1}};
					if (!nsel_n[1])
						m[`BBW_NIB1_HI:`BBW_NIB1_LO] = {(`BBW_NIB1_HI-`BBW_NIB1_LO+1){1'b1}};
				end
				`BBW_MODE_X9: begin
					if (!bsel_n[0])
						m[`BBW_BYTE0_HI:0] = {(`BBW_BYTE0_HI+1){1'b1}};
				end
				`BBW_MODE_X18: begin
					if (!bsel_n[0])
						m[`BBW_BYTE0_HI:0] = {(`BBW_BYTE0_HI+1){1'b1}};
					if (!bsel_n[1])
						m[`BBW_BYTE1_HI:`BBW_BYTE1_LO] = {(`BBW_BYTE1_HI-`BBW_BYTE1_LO+1){1'b1}};
				end
				`BBW_MODE_X36: begin
					if (!bsel_n[0])
						m[`BBW_BYTE0_HI:0] = {(`BBW_BYTE0_HI+1){1'b1}};
					if (!bsel_n[1])
						m[`BBW_BYTE1_HI:`BBW_BYTE1_LO] = {(`BBW_BYTE1_HI-`BBW_BYTE1_LO+1){1'b1}};
					if (!bsel_n[2])
						m[`BBW_BYTE2_HI:`BBW_BYTE2_LO] = {(`BBW_BYTE2_HI-`BBW_BYTE2_LO+1){1'b1}};
					if (!bsel_n[3])
						m[`BBW_BYTE3_HI:`BBW_BYTE3_LO] = {(`BBW_BYTE3_HI-`BBW_BYTE3_LO+1){1'b1}};
				end
				default: m = `BBW_ZERO_DW;
			endcase
			// All enables high leave m empty, so nothing is written
			lane_mask = m;
		end
	endfunction

	function [`BBW_DW-1:0] lane_merge;
		input [`BBW_DW-1:0] old_w;
		input [`BBW_DW-1:0] new_w;
		input [`BBW_DW-1:0] mask;
		begin
			lane_merge = (old_w & ~mask) | (new_w & mask);
		end
	endfunction

	function [`BBW_DW-1:0] width_mask;
		input [1:0] mode;
		begin
			case (mode)
				`BBW_MODE_X8: width_mask = {{(`BBW_DW-`BBW_NIB1_HI-1){1'b0}},
					{(`BBW_NIB1_HI+1){1'b1}}};
				`BBW_MODE_X9: width_mask = {{(`BBW_DW-`BBW_BYTE0_HI-1){1'b0}},
					{(`BBW_BYTE0_HI+1){1'b1}}};
				`BBW_MODE_X18: width_mask = {{(`BBW_DW-`BBW_BYTE1_HI-1){1'b0}},
					{(`BBW_BYTE1_HI+1){1'b1}}};
				default: width_mask = `BBW_ONES_DW;
			endcase
		end
	endfunction

	// =============================================================
	// Pin synchronisers; clocks and data share depth so they stay aligned
	reg k_s1_ff, k_s2_ff, k_s3_ff;
	reg kn_s1_ff, kn_s2_ff, kn_s3_ff;
	reg c_s1_ff, c_s2_ff, c_s3_ff;
	reg cn_s1_ff, cn_s2_ff, cn_s3_ff;
	reg [`BBW_AW-1:0] addr_s1_ff, addr_s2_ff;
	reg [`BBW_DW-1:0] d_s1_ff, d_s2_ff;
	reg wps_s1_ff, wps_s2_ff;
	reg rps_s1_ff, rps_s2_ff;
	reg [`BBW_BW-1:0] bsel_s1_ff, bsel_s2_ff;
	reg [`BBW_NW-1:0] nsel_s1_ff, nsel_s2_ff;
	reg [1:0] mode_s1_ff, mode_s2_ff;

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			k_s1_ff <= 1'b0;
			k_s2_ff <= 1'b0;
			k_s3_ff <= 1'b0;
			kn_s1_ff <= 1'b0;
			kn_s2_ff <= 1'b0;
			kn_s3_ff <= 1'b0;
			c_s1_ff <= 1'b0;
			c_s2_ff <= 1'b0;
			c_s3_ff <= 1'b0;
			cn_s1_ff <= 1'b0;
			cn_s2_ff <= 1'b0;
			cn_s3_ff <= 1'b0;
			addr_s1_ff <= {`BBW_AW{1'b0}};
			addr_s2_ff <= {`BBW_AW{1'b0}};
			d_s1_ff <= `BBW_ZERO_DW;
			d_s2_ff <= `BBW_ZERO_DW;
			wps_s1_ff <= 1'b1;
			wps_s2_ff <= 1'b1;
			rps_s1_ff <= 1'b1;
			rps_s2_ff <= 1'b1;
			bsel_s1_ff <= {`BBW_BW{1'b1}};
			bsel_s2_ff <= {`BBW_BW{1'b1}};
			nsel_s1_ff <= {`BBW_NW{1'b1}};
			nsel_s2_ff <= {`BBW_NW{1'b1}};
			mode_s1_ff <= `BBW_MODE_X36;
			mode_s2_ff <= `BBW_MODE_X36;
		end else begin
			k_s1_ff <= k_i;
			k_s2_ff <= k_s1_ff;
			k_s3_ff <= k_s2_ff;
			kn_s1_ff <= k_n_i;
			kn_s2_ff <= kn_s1_ff;
			kn_s3_ff <= kn_s2_ff;
			c_s1_ff <= c_i;
			c_s2_ff <= c_s1_ff;
			c_s3_ff <= c_s2_ff;
			cn_s1_ff <= c_n_i;
			cn_s2_ff <= cn_s1_ff;
			cn_s3_ff <= cn_s2_ff;
			addr_s1_ff <= addr_i;
			addr_s2_ff <= addr_s1_ff;
			d_s1_ff <= d_i;
			d_s2_ff <= d_s1_ff;
			wps_s1_ff <= write_port_select_n_i;
			wps_s2_ff <= wps_s1_ff;
			rps_s1_ff <= read_port_select_n_i;
			rps_s2_ff <= rps_s1_ff;
			bsel_s1_ff <= byte_lane_write_enable_n_i;
			bsel_s2_ff <= bsel_s1_ff;
			nsel_s1_ff <= nibble_lane_write_enable_n_i;
			nsel_s2_ff <= nsel_s1_ff;
			mode_s1_ff <= cfg_mode_i;
			mode_s2_ff <= mode_s1_ff;
		end
	end

	// =============================================================
	// Straps, caught once the synchronisers no longer hold their reset value
	reg strap_done_ff;
	reg [1:0] strap_dly_ff;
	reg [1:0] mode_ff;

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			strap_done_ff <= 1'b0;
			strap_dly_ff <= 2'h0;
			mode_ff <= `BBW_MODE_X36;
			single_clock_mode_o <= 1'b0;
		end else begin
			strap_dly_ff <= {strap_dly_ff[0], 1'b1};
			if (strap_dly_ff[1] && !strap_done_ff) begin
				strap_done_ff <= 1'b1;
				mode_ff <= mode_s2_ff;
				// C and C# tied high select single clock mode
				single_clock_mode_o <= c_s2_ff & cn_s2_ff;
			end
		end
	end

	wire k_rise = k_s2_ff & ~k_s3_ff & strap_done_ff;
	wire kn_rise = kn_s2_ff & ~kn_s3_ff & strap_done_ff;
	wire opos_rise = single_clock_mode_o ? k_rise : (c_s2_ff & ~c_s3_ff);
	wire oneg_rise = single_clock_mode_o ? kn_rise : (cn_s2_ff & ~cn_s3_ff);
	wire [`BBW_DW-1:0] beat_mask = lane_mask(mode_ff, bsel_s2_ff, nsel_s2_ff);
	wire [`BBW_DW-1:0] beat_data = d_s2_ff & width_mask(mode_ff);

	// =============================================================
	// Write sequencer
	reg [2:0] wr_state_ff;
	reg [2:0] nxt_wr_state;
	reg [`BBW_AW-1:0] wr_addr_ff;
	reg [`BBW_DW-1:0] wr_d0_ff, wr_d1_ff;
	reg [`BBW_DW-1:0] wr_m0_ff, wr_m1_ff;
	wire wr_start = k_rise & ~wps_s2_ff;

	always @* begin
		nxt_wr_state = wr_state_ff;
		case (wr_state_ff)
			`BBW_WR_IDLE: begin
				if (wr_start)
					nxt_wr_state = `BBW_WR_BEAT0;
			end
			`BBW_WR_BEAT0: begin
				if (kn_rise)
					nxt_wr_state = `BBW_WR_COMMIT;
			end
			`BBW_WR_COMMIT: begin
				nxt_wr_state = wr_start ? `BBW_WR_BEAT0 : `BBW_WR_IDLE;
			end
			default: nxt_wr_state = `BBW_WR_IDLE;
		endcase
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_state_ff <= `BBW_WR_IDLE;
			wr_addr_ff <= {`BBW_AW{1'b0}};
			wr_d0_ff <= `BBW_ZERO_DW;
			wr_d1_ff <= `BBW_ZERO_DW;
			wr_m0_ff <= `BBW_ZERO_DW;
			wr_m1_ff <= `BBW_ZERO_DW;
		end else begin
			wr_state_ff <= nxt_wr_state;
			if (wr_start && wr_state_ff != `BBW_WR_BEAT0) begin
				wr_d0_ff <= beat_data;
				wr_m0_ff <= beat_mask;
			end
			if (kn_rise && wr_state_ff == `BBW_WR_BEAT0) begin
				wr_addr_ff <= addr_s2_ff;
				wr_d1_ff <= beat_data;
				wr_m1_ff <= beat_mask;
			end
		end
	end

	// =============================================================
	// Storage; two words per burst address
	reg [`BBW_DW-1:0] mem [0:`BBW_DEPTH-1];
	wire wr_commit = (wr_state_ff == `BBW_WR_COMMIT);
	wire [`BBW_MW-1:0] wr_idx0 = {wr_addr_ff, `BBW_BEAT_LO};
	wire [`BBW_MW-1:0] wr_idx1 = {wr_addr_ff, `BBW_BEAT_HI};

	// No reset on the array; contents are undefined until written
	always @(posedge clk_i) begin
		if (wr_commit) begin
			mem[wr_idx0] <= lane_merge(mem[wr_idx0], wr_d0_ff, wr_m0_ff);
			mem[wr_idx1] <= lane_merge(mem[wr_idx1], wr_d1_ff, wr_m1_ff);
		end
	end

	// =============================================================
	// Read request and fetch (request at t, fetch at next K rise t+1)
	reg rd_pend_ff;
	reg [`BBW_AW-1:0] rd_addr_ff;
	reg [`BBW_DW-1:0] fetch_w0_ff, fetch_w1_ff;
	reg fetch_vld_ff;
	wire out_take;
	wire [`BBW_MW-1:0] rd_idx0 = {rd_addr_ff, `BBW_BEAT_LO};
	wire [`BBW_MW-1:0] rd_idx1 = {rd_addr_ff, `BBW_BEAT_HI};

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_pend_ff <= 1'b0;
			rd_addr_ff <= {`BBW_AW{1'b0}};
			fetch_w0_ff <= `BBW_ZERO_DW;
			fetch_w1_ff <= `BBW_ZERO_DW;
			fetch_vld_ff <= 1'b0;
		end else begin
			if (k_rise) begin
				rd_pend_ff <= ~rps_s2_ff;
				rd_addr_ff <= addr_s2_ff;
				if (rd_pend_ff) begin
					fetch_w0_ff <= mem[rd_idx0] & width_mask(mode_ff);
					fetch_w1_ff <= mem[rd_idx1] & width_mask(mode_ff);
				end
			end
			// Set wins over the sequencer taking the fetched burst
			if (k_rise && rd_pend_ff)
				fetch_vld_ff <= 1'b1;
			else if (out_take)
				fetch_vld_ff <= 1'b0;
		end
	end

	// =============================================================
	// Read output sequencer
	reg [3:0] out_state_ff;
	reg [3:0] nxt_out_state;
	reg [`BBW_DW-1:0] sec_w_ff;
	assign out_take = oneg_rise & fetch_vld_ff &
		(out_state_ff == `BBW_OUT_ARM || out_state_ff == `BBW_OUT_W1);

	always @* begin
		nxt_out_state = out_state_ff;
		case (out_state_ff)
			`BBW_OUT_IDLE: begin
				if (fetch_vld_ff)
					nxt_out_state = `BBW_OUT_ARM;
			end
			`BBW_OUT_ARM: begin
				if (out_take)
					nxt_out_state = `BBW_OUT_W0;
			end
			`BBW_OUT_W0: begin
				if (opos_rise)
					nxt_out_state = `BBW_OUT_W1;
			end
			`BBW_OUT_W1: begin
				// Back-to-back burst continues without a gap
				if (out_take)
					nxt_out_state = `BBW_OUT_W0;
				else if (oneg_rise)
					nxt_out_state = `BBW_OUT_IDLE;
			end
			default: nxt_out_state = `BBW_OUT_IDLE;
		endcase
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			out_state_ff <= `BBW_OUT_IDLE;
			sec_w_ff <= `BBW_ZERO_DW;
			q_o <= `BBW_ZERO_DW;
			q_oe_o <= 1'b0;
		end else begin
			out_state_ff <= nxt_out_state;
			if (out_take) begin
				q_o <= fetch_w0_ff;
				sec_w_ff <= fetch_w1_ff;
				q_oe_o <= 1'b1;
			end else if (out_state_ff == `BBW_OUT_W0 && opos_rise) begin
				q_o <= sec_w_ff;
			end else if (out_state_ff == `BBW_OUT_W1 && oneg_rise) begin
				// Release after the next output rise for depth expansion
				q_oe_o <= 1'b0;
			end
		end
	end

endmodule // bbw_burst_sram

/* include/bbw_defines.vh */
`ifndef BBW_DEFINES_VH
`define BBW_DEFINES_VH

// =============================================================
// Widths
`define BBW_DW 36
`define BBW_AW 8
`define BBW_MW 9
`define BBW_DEPTH 512
`define BBW_BW 4
`define BBW_NW 2

// =============================================================
// Width configurations (strap)
`define BBW_MODE_X8 2'h0
`define BBW_MODE_X9 2'h1
`define BBW_MODE_X18 2'h2
`define BBW_MODE_X36 2'h3

// =============================================================
// Lane boundaries
`define BBW_NIB0_HI 3
`define BBW_NIB1_LO 4
`define BBW_NIB1_HI 7
`define BBW_BYTE0_HI 8
`define BBW_BYTE1_LO 9
`define BBW_BYTE1_HI 17
`define BBW_BYTE2_LO 18
`define BBW_BYTE2_HI 26
`define BBW_BYTE3_LO 27
`define BBW_BYTE3_HI 35

// =============================================================
// Write sequencer states (one-hot)
`define BBW_WR_IDLE 3'h1
`define BBW_WR_BEAT0 3'h2
`define BBW_WR_COMMIT 3'h4

// =============================================================
// Read output sequencer states (one-hot)
`define BBW_OUT_IDLE 4'h1
`define BBW_OUT_ARM 4'h2
`define BBW_OUT_W0 4'h4
`define BBW_OUT_W1 4'h8

// =============================================================
// Misc constants
`define BBW_ZERO_DW 36'h000000000
`define BBW_ONES_DW 36'hFFFFFFFFF
`define BBW_BEAT_LO 1'h0
`define BBW_BEAT_HI 1'h1

`endif

/* verification/bbw_burst_sram_props.sv */
`timescale 1ns/1ps
`include "bbw_defines.vh"

// ==========
// Read-side output checks
module bbw_sram_chk (
	input wire clk_i,
	input wire rst_i,
	input wire k_i,
	input wire k_n_i,
	input wire c_i,
	input wire c_n_i,
	input wire read_port_select_n_i,
	input wire [`BBW_DW-1:0] q_o,
	input wire q_oe_o,
	input wire single_clock_mode_o
);
	reg [9:0] rd_age_ff;
	reg [3:0] kn_age_ff;
	reg [3:0] kany_age_ff;
	reg [2:0] rel_ff;

	// Ages saturate so a stopped clock never wraps into a false pass
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_age_ff <= 10'h3FF;
			kn_age_ff <= 4'hF;
			kany_age_ff <= 4'hF;
			rel_ff <= 3'h0;
		end else begin
			rd_age_ff <= read_port_select_n_i ?
				rd_age_ff + {9'h000, rd_age_ff != 10'h3FF} : 10'h000;
			kn_age_ff <= $rose(k_n_i) ? 4'h0 : kn_age_ff + {3'h0, kn_age_ff != 4'hF};
			kany_age_ff <= ($rose(k_i) || $rose(k_n_i)) ? 4'h0 :
				kany_age_ff + {3'h0, kany_age_ff != 4'hF};
			rel_ff <= rel_ff + {2'h0, rel_ff != 3'h7};
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	chk_oe_reset: assert property ($fell(rst_i) |-> !q_oe_o [*3])
		else $error("output enable up right after reset");
	chk_oe_cause: assert property ($rose(q_oe_o) |-> rd_age_ff < 10'h3E8)
		else $error("output enable without a read request");
	chk_oe_launch: assert property ($rose(q_oe_o) && single_clock_mode_o |-> kn_age_ff <= 4'h6)
		else $error("first word not launched by negative clock rise");
	chk_q_launch: assert property (!$stable(q_o) && single_clock_mode_o |-> kany_age_ff <= 4'h6)
		else $error("read data changed away from a clock rise");
	chk_q_quiet: assert property (!q_oe_o |-> $stable(q_o))
		else $error("read data moved while not driven");
	chk_oe_hold: assert property ($rose(q_oe_o) |-> q_oe_o [*3])
		else $error("burst output dropped too early");
	chk_oe_idle: assert property (rd_age_ff > 10'h0C8 |-> !q_oe_o)
		else $error("output driven long after last read");
	chk_strap_val: assert property (rel_ff == 3'h5 |-> single_clock_mode_o == (c_i && c_n_i))
		else $error("single clock strap wrong");

	cov_read: cover property ($rose(q_oe_o));
	cov_drop: cover property ($fell(q_oe_o));
	cov_strap: cover property (rel_ff == 3'h5 && single_clock_mode_o);
endmodule // bbw_sram_chk

bind bbw_burst_sram bbw_sram_chk u_chk (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.k_i(k_i),
	.k_n_i(k_n_i),
	.c_i(c_i),
	.c_n_i(c_n_i),
	.read_port_select_n_i(read_port_select_n_i),
	.q_o(q_o),
	.q_oe_o(q_oe_o),
	.single_clock_mode_o(single_clock_mode_o)
);

/* verification/bbw_ctl_model.sv */
`timescale 1ns/1ps
`include "bbw_defines.vh"

// ==========
// Memory controller model
module bbw_ctl_model (
	input wire clk_i,
	input wire [`BBW_DW-1:0] q_i,
	input wire q_oe_i,
	output reg k_o,
	output reg k_n_o,
	output reg c_o,
	output reg c_n_o,
	output reg [`BBW_AW-1:0] addr_o,
	output reg [`BBW_DW-1:0] d_o,
	output reg write_port_select_n_o,
	output reg read_port_select_n_o,
	output reg [`BBW_BW-1:0] byte_lane_write_enable_n_o,
	output reg [`BBW_NW-1:0] nibble_lane_write_enable_n_o
);
	reg dual;

	// Output clocks parked high: single clock mode
	initial begin
		dual = 1'h0;
		k_o = 1'h0;
		k_n_o = 1'h0;
		c_o = 1'h1;
		c_n_o = 1'h1;
		addr_o = 8'h00;
		d_o = `BBW_ZERO_DW;
		write_port_select_n_o = 1'h1;
		read_port_select_n_o = 1'h1;
		byte_lane_write_enable_n_o = 4'hF;
		nibble_lane_write_enable_n_o = 2'h3;
	end

	task tick(input integer n);
		begin
			repeat (n) @(posedge clk_i);
			#1;
		end
	endtask

	task strap(input v);
		begin
			c_o = v;
			c_n_o = v;
			dual = !v;
		end
	endtask

	// Rise of K (kn=0) or K# (kn=1); both parked low between rises
	task rise(input kn);
		begin
			k_o = !kn;
			k_n_o = kn;
			if (dual) begin
				c_o = !kn;
				c_n_o = kn;
			end
			tick(4);
			k_o = 1'h0;
			k_n_o = 1'h0;
			if (dual) begin
				c_o = 1'h0;
				c_n_o = 1'h0;
			end
			tick(3);
		end
	endtask

	task wr(input [7:0] a, input [35:0] d0, input [35:0] d1,
		input [5:0] e0, input [5:0] e1, input ws);
		begin
			write_port_select_n_o = ws;
			d_o = d0;
			{nibble_lane_write_enable_n_o, byte_lane_write_enable_n_o} = e0;
			tick(3);
			rise(1'h0);
			write_port_select_n_o = 1'h1;
			addr_o = a;
			d_o = d1;
			{nibble_lane_write_enable_n_o, byte_lane_write_enable_n_o} = e1;
			tick(3);
			rise(1'h1);
			addr_o = ~a;
			d_o = ~d1;
			tick(1);
		end
	endtask

	task rd(input [7:0] a, output [35:0] w0, output [35:0] w1, output oe0, output oe2);
		begin
			read_port_select_n_o = 1'h0;
			addr_o = a;
			tick(3);
			rise(1'h0);
			read_port_select_n_o = 1'h1;
			addr_o = ~a;
			rise(1'h1);
			rise(1'h0);
			rise(1'h1);
			w0 = q_i;
			oe0 = q_oe_i;
			rise(1'h0);
			w1 = q_i;
			rise(1'h1);
			oe2 = q_oe_i;
		end
	endtask
endmodule // bbw_ctl_model

/* verification/test_burst_byte_write_masking.sv */
`timescale 1ns/1ps
`include "bbw_defines.vh"

module test_burst_byte_write_masking;
	reg clk_i;
	reg rst_i;
	reg [1:0] cfg_mode_i;
	wire k_i, k_n_i, c_i, c_n_i, wps_n, rps_n, q_oe_o, single_clock_mode_o;
	wire [7:0] addr_i;
	wire [35:0] d_i, q_o;
	wire [3:0] byte_n;
	wire [1:0] nib_n;
	integer failures;
	integer check_count;
	reg [35:0] w0, w1;
	reg oe0, oe2;

	bbw_burst_sram dut (.clk_i(clk_i), .rst_i(rst_i), .k_i(k_i), .k_n_i(k_n_i),
		.c_i(c_i), .c_n_i(c_n_i), .cfg_mode_i(cfg_mode_i), .addr_i(addr_i), .d_i(d_i),
		.write_port_select_n_i(wps_n), .read_port_select_n_i(rps_n),
		.byte_lane_write_enable_n_i(byte_n), .nibble_lane_write_enable_n_i(nib_n),
		.q_o(q_o), .q_oe_o(q_oe_o), .single_clock_mode_o(single_clock_mode_o));

	bbw_ctl_model u_ctl (.clk_i(clk_i), .q_i(q_o), .q_oe_i(q_oe_o), .k_o(k_i),
		.k_n_o(k_n_i), .c_o(c_i), .c_n_o(c_n_i), .addr_o(addr_i), .d_o(d_i),
		.write_port_select_n_o(wps_n), .read_port_select_n_o(rps_n),
		.byte_lane_write_enable_n_o(byte_n), .nibble_lane_write_enable_n_o(nib_n));

	initial begin
		clk_i = 1'h0;
		forever #20 clk_i = ~clk_i;
	end

	task check(input [35:0] seen, input [35:0] exp);
		begin
			check_count = check_count + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask

	task end_sim;
		begin
			$display("failures %0d checks %0d", failures, check_count);
			if (failures == 0 && check_count > 0) begin
				$display("STATUS OK");
			end else begin
				$display("STATUS NOT OK");
			end
			$finish;
		end
	endtask

	task do_reset(input [1:0] m);
		begin
			cfg_mode_i = m;
			rst_i = 1'h1;
			repeat (4) @(posedge clk_i);
			#1;
			rst_i = 1'h0;
			repeat (4) @(posedge clk_i);
			#1;
		end
	endtask

	// Bits a beat may change for mode m and enables e = {nibble, byte}
	function [35:0] lanes(input [1:0] m, input [5:0] e);
		case (m)
		2'h0: lanes = {28'h0, {4{!e[5]}}, {4{!e[4]}}};
		2'h1: lanes = {27'h0, {9{!e[0]}}};
		2'h2: lanes = {18'h0, {9{!e[1]}}, {9{!e[0]}}};
		default: lanes = {{9{!e[3]}}, {9{!e[2]}}, {9{!e[1]}}, {9{!e[0]}}};
		endcase
	endfunction

	// Unused lane group held low so a mixup of the two groups shows
	function [5:0] en(input [1:0] m, input integer i);
		reg [3:0] t;
		begin
			t = (i == 0) ? 4'h0 : (i == 5) ? 4'hF : ~(4'h1 << (i - 1));
			case (m)
			2'h0: en = {i[1:0], 4'h0};
			2'h1: en = {5'h00, i[0]};
			2'h2: en = {4'h0, i[1:0]};
			default: en = {2'h0, t};
			endcase
		end
	endfunction

	task t_power;
		begin
			u_ctl.strap(1'h0);
			do_reset(`BBW_MODE_X36);
			check({35'h0, single_clock_mode_o}, 36'h0);
			u_ctl.wr(8'h20, 36'h3C96A5F0E, 36'hC3695A0F1, 6'h00, 6'h00, 1'h0);
			u_ctl.rd(8'h20, w0, w1, oe0, oe2);
			check(w0, 36'h3C96A5F0E);
			check(w1, 36'hC3695A0F1);
			check({34'h0, oe0, oe2}, 36'h2);
			u_ctl.strap(1'h1);
			do_reset(`BBW_MODE_X36);
			check({35'h0, single_clock_mode_o}, 36'h1);
			u_ctl.wr(8'h10, 36'h3C96A5F0E, 36'hC3695A0F1, 6'h3F, 6'h3F, 1'h1);
			check({35'h0, q_oe_o}, 36'h0);
			check(q_o, 36'h0);
		end
	endtask

	task t_lanes(input [1:0] m, input integer n, input [7:0] a);
		reg [35:0] wm, p, q, m0, m1;
		integer i;
		begin
			do_reset(m);
			wm = lanes(m, 6'h00);
			p = 36'h3C96A5F0E;
			q = 36'hC3695A0F1;
			for (i = 0; i < n; i = i + 1) begin
				m0 = lanes(m, en(m, i));
				m1 = lanes(m, en(m, (i + 1) % n));
				u_ctl.wr(a + i[7:0], p, q, 6'h00, 6'h00, 1'h0);
				u_ctl.wr(a + i[7:0], ~p, ~q, en(m, i), en(m, (i + 1) % n), 1'h0);
				u_ctl.rd(a + i[7:0], w0, w1, oe0, oe2);
				check(w0, ((p & ~m0) | (~p & m0)) & wm);
				check(w1, ((q & ~m1) | (~q & m1)) & wm);
				check({34'h0, oe0, oe2}, 36'h2);
			end
		end
	endtask

	task t_deselect;
		begin
			u_ctl.wr(8'h00, ~36'h0, 36'h0, 6'h3F, 6'h00, 1'h1);
			u_ctl.rd(8'h00, w0, w1, oe0, oe2);
			check(w0, 36'h3C96A5F0E);
			check(w1, 36'hC3695A0F1);
		end
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		failures = failures + 1;
		end_sim;
	end

	initial begin
		rst_i = 1'h1;
		cfg_mode_i = `BBW_MODE_X36;
		failures = 0;
		check_count = 0;
		t_power;
		t_lanes(`BBW_MODE_X8, 4, 8'h00);
		t_lanes(`BBW_MODE_X9, 2, 8'h40);
		t_lanes(`BBW_MODE_X18, 4, 8'h80);
		t_lanes(`BBW_MODE_X36, 6, 8'hFA);
		u_ctl.wr(8'h00, 36'h3C96A5F0E, 36'hC3695A0F1, 6'h00, 6'h00, 1'h0);
		t_deselect;
		end_sim;
	end
endmodule // test_burst_byte_write_masking
